// ===== rtl/clhp_top.sv
// Functional notes
// (R1) Write selects command or transfer latch
// (R2) Status read: busy bit 7, pointer below
// (R3) Data read returns transfer latch
// (R4) Accesses only while chip select high
// (R5) Bus driven only during reads
// (R6) Four-bit mode uses upper lines only
// (R7) Command latch is never read back
// (R8) Data write stores into addressed memory
// (R9) Address write prefetches addressed byte
// (R10) Pointer steps after each data access
// (R11) Busy blocks all but status read
// (R12) Host polls busy before each command
// (R13) Seven-bit pointer, last address picks memory
// (R14) Text memory holds eighty bytes
// (R15) One-line view starts at address 00
// (R16) Second line starts at address 40
// (R17) One expander shows 24 per line
// (R18) Each further expander adds sixteen, one-line
// (R19) Two-line mode: two expanders, forty each
// (R20) Font table, short font uses upper rows
// (R21) Unused rows stay unselected per duty
// (R22) Serial dot: one lit, zero dark
// (R23) Shift rotates view, memory untouched
// (R24) Shift clock, row latch, polarity toggle
module clhp_top import clhp_pkg::*; #(
    parameter int NUM_EXP = 0
) (
    input  wire logic        MCLK,                // Core clock, 20 MHz
    input  wire logic        ARST_N,              // Async reset, active low
    input  wire logic        REGISTER_SELECT,     // Low command, high data
    input  wire logic        DIRECTION_SELECT,    // Low write, high read
    input  wire logic        CHIP_SELECT,         // Frames each access
    input  wire logic [7:0]  HOST_BUS_LINES_I,    // Bus pins in
    output logic      [7:0]  HOST_BUS_LINES_O,    // Bus pins out
    output logic      [7:0]  HOST_BUS_LINES_OE,   // Bus drive enables
    output logic             BUSY_INDICATOR,      // Instruction running
    output logic             SERIAL_DOTS,         // Expansion dot data
    output logic             COLUMN_SHIFT_CLOCK,  // Expansion shift clock
    output logic             ROW_LATCH_PULSE,     // Row latch
    output logic             ALTERNATION_SIGNAL,  // Drive polarity
    output logic      [15:0] ROW_DRIVE,           // Row select, high active
    output logic      [39:0] COLUMN_DRIVE         // On-chip column dots
);

    if (NUM_EXP < 0 || NUM_EXP > MAX_EXP_ONE) begin : g_bad_exp
        $error("clhp_top: bad NUM_EXP");
    end

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic              rs1;
        logic              rs2;
        logic              dir1;
        logic              dir2;
        logic              cs1;
        logic              cs2;
        logic              cs3;
        logic [7:0]        d1;
        logic [7:0]        d2;
        logic [7:0]        wbyte;
        logic [3:0]        hold;
        logic [7:0]        cmd;
        logic [7:0]        xfer;
        logic [7:0]        bus_out;
        logic [6:0]        ptr;
        logic [6:0]        shift;
        logic              glyph_sel;
        logic              inc;
        logic              wide;
        logic              two_line;
        logic              tall;
        logic              nib;
        logic              wr_pend;
        logic              fetch;
        logic [BUSY_W-1:0] busy;
    } clhp_state_t;

    clhp_state_t s, n;

    // ****************************************
    // Helpers
    // ****************************************
    // Next pointer; text lines wrap into each other, glyph space wraps at 64
    function automatic logic [6:0] step_ptr(input logic [6:0] a, input logic up,
                                            input logic g, input logic two);
        logic [6:0] r;
        r = up ? a + PTR_ONE : a - PTR_ONE;
        if (g) begin
            r = {1'b0, r[5:0]};
        end else if (!two) begin
            if (up && a == TEXT_LAST_1) begin
                r = PTR_ZERO;
            end else if (!up && a == PTR_ZERO) begin
                r = TEXT_LAST_1;
            end
        end else if (up) begin
            if (a == LINE1_LAST_2) begin
                r = LINE2_BASE;
            end else if (a == LINE2_LAST_2) begin
                r = PTR_ZERO;
            end
        end else begin
            if (a == LINE2_BASE) begin
                r = LINE1_LAST_2;
            end else if (a == PTR_ZERO) begin
                r = LINE2_LAST_2;
            end
        end
        return r;
    endfunction

    // Pointer to linear text index; the second line is packed after the first
    function automatic logic [6:0] text_index(input logic [6:0] a, input logic two);
        return (two && a >= LINE2_BASE) ? 7'(a - LINE2_BASE + LINE_LEN_TWO) : a;
    endfunction

    // ****************************************
    // Memories and scan
    // ****************************************
    logic [7:0] txt_ra;
    logic [7:0] txt_rb;
    logic [7:0] gly_ra;
    logic [7:0] gly_rb;
    logic [6:0] scan_txt_addr;
    logic [5:0] scan_gly_addr;
    logic [6:0] host_txt_addr;

    assign host_txt_addr = text_index(s.ptr, s.two_line);

    clhp_mem #(
        .DEPTH (TEXT_DEPTH),                                                        // R14
        .WIDTH (DATA_W),
        .AW    (PTR_W)
    ) u_text (
        .clk     (MCLK),
        .wr_en   (s.wr_pend && !s.glyph_sel),                                       // R8
        .wr_addr (host_txt_addr),
        .wr_data (s.xfer),
        .ra_addr (host_txt_addr),
        .ra_data (txt_ra),
        .rb_addr (scan_txt_addr),
        .rb_data (txt_rb)
    );

    clhp_mem #(
        .DEPTH (GLYPH_DEPTH),
        .WIDTH (DATA_W),
        .AW    (GLYPH_AW)
    ) u_glyph (
        .clk     (MCLK),
        .wr_en   (s.wr_pend && s.glyph_sel),                                        // R8
        .wr_addr (s.ptr[5:0]),
        .wr_data (s.xfer),
        .ra_addr (s.ptr[5:0]),
        .ra_data (gly_ra),
        .rb_addr (scan_gly_addr),
        .rb_data (gly_rb)
    );

    clhp_scan #(
        .NUM_EXP (NUM_EXP)
    ) u_scan (
        .clk      (MCLK),
        .arst_n   (ARST_N),
        .two_line (s.two_line),
        .tall     (s.tall),
        .shift    (s.shift),
        .txt_data (txt_rb),
        .gly_data (gly_rb),
        .txt_addr (scan_txt_addr),
        .gly_addr (scan_gly_addr),
        .ser_data (SERIAL_DOTS),
        .sck      (COLUMN_SHIFT_CLOCK),
        .latch    (ROW_LATCH_PULSE),
        .alt      (ALTERNATION_SIGNAL),
        .rows     (ROW_DRIVE),
        .cols     (COLUMN_DRIVE)
    );

    // ****************************************
    // Host access
    // ****************************************
    logic       is_busy;
    logic       cs_rise;
    logic       cs_fall;
    logic       whole;
    logic [7:0] byte_in;
    logic [7:0] rd_src;
    logic [6:0] line_len;

    always_comb begin
        n          = s;
        n.rs1      = REGISTER_SELECT;
        n.rs2      = s.rs1;
        n.dir1     = DIRECTION_SELECT;
        n.dir2     = s.dir1;
        n.cs1      = CHIP_SELECT;
        n.cs2      = s.cs1;
        n.cs3      = s.cs2;
        n.d1       = HOST_BUS_LINES_I;
        n.d2       = s.d1;
        n.wr_pend  = 1'b0;
        n.fetch    = 1'b0;
        is_busy    = (s.busy != '0);
        cs_rise    = s.cs2 && !s.cs3;                                               // R4
        cs_fall    = !s.cs2 && s.cs3;                                               // R4
        whole      = s.wide || s.nib;                                               // R6
        byte_in    = s.wide ? s.wbyte : {s.hold, s.wbyte[7:4]};                     // R6
        line_len   = s.two_line ? LINE_LEN_TWO : LINE_LEN_ONE;
        // Command latch has no read path at all
        rd_src     = s.rs2 ? s.xfer : {is_busy, s.ptr};                             // R2 R3 R7

        if (is_busy) begin
            n.busy = s.busy - BUSY_W'(1);
        end

        // Data lines are sampled through the last cycle of a write
        if (s.cs2 && !s.dir2) begin
            n.wbyte = s.d2;
        end

        // Read data is frozen at the start of the cycle so the pins stay steady
        if (cs_rise && s.dir2) begin
            n.bus_out = (!s.wide && s.nib) ? {rd_src[3:0], 4'h0} : rd_src;          // R6
        end

        if (cs_fall) begin
            if (!s.wide) begin
                n.nib = ~s.nib;
                if (!s.nib) begin
                    n.hold = s.wbyte[7:4];
                end
            end
            // Only status reads get through while busy
            if (whole && !is_busy) begin                                            // R11
                case ({s.rs2, s.dir2})
                    2'b00: begin
                        n.cmd  = byte_in;                                           // R1
                        n.busy = BUSY_W'(EXEC_CYC);                                 // R11
                        if (byte_in[CMD_TEXT_ADDR]) begin
                            n.ptr       = byte_in[6:0];                             // R13
                            n.glyph_sel = 1'b0;
                            n.fetch     = 1'b1;                                     // R9
                        end else if (byte_in[CMD_GLYPH_ADDR]) begin
                            n.ptr       = {1'b0, byte_in[5:0]};                     // R13
                            n.glyph_sel = 1'b1;
                            n.fetch     = 1'b1;                                     // R9
                        end else if (byte_in[CMD_FUNC_SET]) begin
                            n.wide      = byte_in[FS_WIDE_BIT];
                            n.two_line  = byte_in[FS_TWO_LINE_BIT];
                            n.tall      = byte_in[FS_TALL_BIT];
                            n.shift     = PTR_ZERO;
                            n.nib       = 1'b0;
                        end else if (byte_in[CMD_SHIFT]) begin
                            if (!byte_in[SH_DISPLAY_BIT]) begin
                                n.ptr = step_ptr(s.ptr, !byte_in[SH_RIGHT_BIT],
                                                 s.glyph_sel, s.two_line);
                            end else if (!byte_in[SH_RIGHT_BIT]) begin
                                n.shift = (s.shift == line_len - PTR_ONE) ? PTR_ZERO
                                        : s.shift + PTR_ONE;                        // R23
                            end else begin
                                n.shift = (s.shift == PTR_ZERO) ? line_len - PTR_ONE
                                        : s.shift - PTR_ONE;                        // R23
                            end
                        end else if (byte_in[CMD_ENTRY]) begin
                            n.inc = byte_in[EN_UP_BIT];
                        end
                    end
                    2'b10: begin
                        n.xfer    = byte_in;                                        // R1
                        n.wr_pend = 1'b1;                                           // R8
                        n.busy    = BUSY_W'(EXEC_CYC);
                    end
                    2'b11: begin
                        n.ptr   = step_ptr(s.ptr, s.inc, s.glyph_sel, s.two_line);  // R10
                        n.fetch = 1'b1;
                        n.busy  = BUSY_W'(EXEC_CYC);
                    end
                    default: begin
                    end
                endcase
            end
        end

        // Memory write lands this cycle, then the pointer moves on
        if (s.wr_pend) begin
            n.ptr = step_ptr(s.ptr, s.inc, s.glyph_sel, s.two_line);                // R10
        end

        if (s.fetch) begin
            n.xfer = s.glyph_sel ? gly_ra : txt_ra;                                 // R9
        end
    end

    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            s      <= '0;
            s.wide <= 1'b1;
            s.inc  <= 1'b1;
        end else begin
            s <= n;
        end
    end

    // ****************************************
    // Pins
    // ****************************************
    assign HOST_BUS_LINES_O          = s.bus_out;
    // Drive only while a framed read is in progress
    assign HOST_BUS_LINES_OE[7:4]    = {4{s.cs2 && s.dir2}};                        // R5
    assign HOST_BUS_LINES_OE[3:0]    = {4{s.cs2 && s.dir2 && s.wide}};              // R5 R6
    assign BUSY_INDICATOR            = (s.busy != '0);                              // R11

endmodule

// ===== rtl/clhp_pkg.sv
package clhp_pkg;

    // ****************************************
    // Host port
    // ****************************************
    localparam int         DATA_W        = 8;
    localparam int         PTR_W         = 7;
    localparam int         NIB_W         = 4;
    localparam logic [6:0] PTR_ZERO      = 7'h00;
    localparam logic [6:0] PTR_ONE       = 7'h01;

    // Command byte decode, the leading one picks the command
    localparam int CMD_TEXT_ADDR   = 7;
    localparam int CMD_GLYPH_ADDR  = 6;
    localparam int CMD_FUNC_SET    = 5;
    localparam int CMD_SHIFT       = 4;
    localparam int CMD_ENTRY       = 2;
    localparam int FS_WIDE_BIT     = 4;
    localparam int FS_TWO_LINE_BIT = 3;
    localparam int FS_TALL_BIT     = 2;
    localparam int SH_DISPLAY_BIT  = 3;
    localparam int SH_RIGHT_BIT    = 2;
    localparam int EN_UP_BIT       = 1;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 50;
    localparam int EXEC_TIME_NS  = 40000;
    localparam int EXEC_CYC      = (EXEC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BUSY_W        = $clog2(EXEC_CYC + 1);

    // ****************************************
    // Memory map
    // ****************************************
    localparam int         TEXT_DEPTH    = 80;
    localparam int         GLYPH_DEPTH   = 64;
    localparam int         GLYPH_AW      = 6;
    localparam logic [6:0] TEXT_LAST_1   = 7'h4f;
    localparam logic [6:0] LINE1_LAST_2  = 7'h27;
    localparam logic [6:0] LINE2_BASE    = 7'h40;
    localparam logic [6:0] LINE2_LAST_2  = 7'h67;
    localparam logic [6:0] LINE_LEN_TWO  = 7'h28;
    localparam logic [6:0] LINE_LEN_ONE  = 7'h50;

    // ****************************************
    // Panel scan
    // ****************************************
    localparam int ROWS_SHORT      = 8;
    localparam int ROWS_TALL       = 11;
    localparam int ROWS_TWO        = 16;
    localparam int CHARS_ONCHIP    = 8;
    localparam int CHARS_FIRST_EXP = 24;
    localparam int CHARS_PER_EXP   = 16;
    localparam int MAX_EXP_ONE     = 5;
    localparam int MAX_EXP_TWO     = 2;
    localparam int DOTS_PER_CHAR   = 5;
    localparam int SEG_COUNT       = 40;
    localparam int GLYPH_CODE_HI   = 4;

endpackage

// ===== rtl/clhp_mem.sv
module clhp_mem #(
    parameter int DEPTH = 80,
    parameter int WIDTH = 8,
    parameter int AW    = 7
) (
    input  wire logic             clk,      // Core clock
    input  wire logic             wr_en,    // Write strobe
    input  wire logic [AW-1:0]    wr_addr,  // Write index
    input  wire logic [WIDTH-1:0] wr_data,  // Write byte
    input  wire logic [AW-1:0]    ra_addr,  // Host read index
    output logic      [WIDTH-1:0] ra_data,  // Host read byte
    input  wire logic [AW-1:0]    rb_addr,  // Scan read index
    output logic      [WIDTH-1:0] rb_data   // Scan read byte
);

    if (DEPTH > (1 << AW)) begin : g_bad_depth
        $error("clhp_mem: DEPTH exceeds address range");
    end

    logic [WIDTH-1:0] mem [DEPTH];

    // Writes past the end are dropped; such reads give zero
    always_ff @(posedge clk) begin
        if (wr_en && (int'(wr_addr) < DEPTH)) begin
            mem[wr_addr] <= wr_data;
        end
    end

    assign ra_data = (int'(ra_addr) < DEPTH) ? mem[ra_addr] : '0;
    assign rb_data = (int'(rb_addr) < DEPTH) ? mem[rb_addr] : '0;

endmodule

// ===== rtl/clhp_scan.sv
module clhp_scan import clhp_pkg::*; #(
    parameter int NUM_EXP = 0
) (
    input  wire logic           clk,       // Core clock
    input  wire logic           arst_n,    // Async reset, active low
    input  wire logic           two_line,  // Two-line mode
    input  wire logic           tall,      // 5x10 font
    input  wire logic [6:0]     shift,     // Display rotation
    input  wire logic [7:0]     txt_data,  // Character code
    input  wire logic [7:0]     gly_data,  // User glyph row
    output logic      [6:0]     txt_addr,  // Text index
    output logic      [5:0]     gly_addr,  // User glyph index
    output logic                ser_data,  // Serial dot
    output logic                sck,       // Shift clock
    output logic                latch,     // Row latch
    output logic                alt,       // Polarity toggle
    output logic      [15:0]    rows,      // Row select
    output logic      [39:0]    cols       // Column dots
);

    if (NUM_EXP < 0 || NUM_EXP > MAX_EXP_ONE) begin : g_bad_exp
        $error("clhp_scan: bad NUM_EXP");
    end

    localparam int LEN1 = (NUM_EXP == 0) ? CHARS_ONCHIP
                        : CHARS_FIRST_EXP + CHARS_PER_EXP * (NUM_EXP - 1);
    localparam int EXP2 = (NUM_EXP > MAX_EXP_TWO) ? MAX_EXP_TWO : NUM_EXP;
    localparam int LEN2 = (EXP2 == 0) ? CHARS_ONCHIP
                        : CHARS_FIRST_EXP + CHARS_PER_EXP * (EXP2 - 1);

    typedef enum logic [0:0] {
        CLHP_SHIFT = 1'b0,
        CLHP_LATCH = 1'b1
    } clhp_scan_st_t;

    typedef struct packed {
        clhp_scan_st_t st;
        logic [3:0]    row;
        logic [6:0]    chr;
        logic [2:0]    dot;
        logic          ph;
        logic          sd;
        logic          sck;
        logic          lp;
        logic          alt;
        logic [39:0]   seg;
        logic [39:0]   col;
        logic [15:0]   rsel;
    } clhp_scan_t;

    clhp_scan_t s, n;

    // Stand-in font; the real pattern set is fixed at mask time
    function automatic logic [4:0] rom_row(input logic [7:0] c, input logic [3:0] r);
        return c[4:0] ^ {r, r[0]};
    endfunction

    logic [3:0] gr;
    logic [6:0] pos;
    logic [6:0] len;
    logic [4:0] pat;
    logic       pix;
    logic [3:0] last_row;

    always_comb begin
        len      = two_line ? 7'(LEN2) : 7'(LEN1);
        last_row = two_line ? 4'(ROWS_TWO - 1) : (tall ? 4'(ROWS_TALL - 1) : 4'(ROWS_SHORT - 1));
        gr       = two_line ? {1'b0, s.row[2:0]} : s.row;
        // Rotation moves every line at once, memory untouched
        pos      = s.chr + shift;                                                    // R23
        if (pos >= (two_line ? LINE_LEN_TWO : LINE_LEN_ONE)) begin
            pos = pos - (two_line ? LINE_LEN_TWO : LINE_LEN_ONE);
        end
        txt_addr = (two_line && s.row[3]) ? 7'(pos + LINE_LEN_TWO) : pos;           // R15 R16
        gly_addr = (tall && !two_line) ? {txt_data[2:1], gr} : {txt_data[2:0], gr[2:0]};
        pat      = (txt_data[7:GLYPH_CODE_HI] == '0) ? gly_data[4:0] : rom_row(txt_data, gr); // R20
        // Last row of the cell is the cursor line, left dark here
        pix      = ((tall && !two_line) ? (gr < 4'(ROWS_TALL - 1)) : (gr < 4'(ROWS_SHORT - 1)))
                 && pat[3'(DOTS_PER_CHAR - 1) - s.dot];
    end

    always_comb begin
        n     = s;
        n.lp  = 1'b0;
        n.sck = 1'b0;
        case (s.st)
            CLHP_SHIFT: begin
                if (!s.ph) begin
                    n.sd = pix;                                                     // R22
                    n.ph = 1'b1;
                end else begin
                    n.sck = 1'b1;                                                   // R24
                    n.ph  = 1'b0;
                    if (s.chr < 7'(CHARS_ONCHIP)) begin
                        n.seg = {s.seg[38:0], s.sd};
                    end
                    if (s.dot == 3'(DOTS_PER_CHAR - 1)) begin
                        n.dot = '0;
                        if (s.chr == len - 7'h01) begin
                            n.chr = '0;
                            n.st  = CLHP_LATCH;
                        end else begin
                            n.chr = s.chr + 7'h01;                                  // R17 R18 R19
                        end
                    end else begin
                        n.dot = s.dot + 3'h1;
                    end
                end
            end
            CLHP_LATCH: begin
                n.lp   = 1'b1;                                                      // R24
                n.col  = s.seg;
                n.rsel = 16'h0001 << s.row;                                         // R21
                n.st   = CLHP_SHIFT;
                if (s.row >= last_row) begin
                    n.row = '0;
                    n.alt = ~s.alt;                                                 // R24
                end else begin
                    n.row = s.row + 4'h1;
                end
            end
            default: n.st = CLHP_SHIFT;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign ser_data = s.sd;
    assign sck      = s.sck;
    assign latch    = s.lp;
    assign alt      = s.alt;
    assign rows     = s.rsel;
    assign cols     = s.col;

endmodule

// ===== tb/clhp_top_asserts.sv
module clhp_chk import clhp_pkg::*; (
    input wire logic        MCLK,               // Clock
    input wire logic        ARST_N,             // Reset
    input wire logic        CHIP_SELECT,        // Frame
    input wire logic        DIRECTION_SELECT,   // Read
    input wire logic [7:0]  HOST_BUS_LINES_OE,  // Drive
    input wire logic        BUSY_INDICATOR,     // Busy
    input wire logic        COLUMN_SHIFT_CLOCK, // Shift
    input wire logic        ROW_LATCH_PULSE,    // Latch
    input wire logic        ALTERNATION_SIGNAL, // Polarity
    input wire logic [15:0] ROW_DRIVE           // Rows
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge MCLK); endclocking
    default disable iff (!ARST_N);
    // Counter instead of a long repetition, which the tools unroll badly
    logic [11:0] bcnt_ff;
    always_ff @(posedge MCLK or negedge ARST_N)
        if (!ARST_N)
            bcnt_ff <= 12'h000;
        else
            bcnt_ff <= BUSY_INDICATOR ? bcnt_ff + 12'h001 : 12'h000;
    property p_oe;
        (|HOST_BUS_LINES_OE[7:4]) == ($past(CHIP_SELECT, 2) && $past(DIRECTION_SELECT, 2));
    endproperty
    a_oe: assert property (p_oe) else $error("bus drive outside read");
    property p_nib; (|HOST_BUS_LINES_OE[3:0]) |-> &HOST_BUS_LINES_OE[7:4]; endproperty
    a_nib: assert property (p_nib) else $error("low lines without high");
    property p_blen; $fell(BUSY_INDICATOR) |-> int'(bcnt_ff) == EXEC_CYC; endproperty
    a_blen: assert property (p_blen) else $error("busy length");
    property p_bsrc; $rose(BUSY_INDICATOR) |-> !$past(CHIP_SELECT); endproperty
    a_bsrc: assert property (p_bsrc) else $error("busy inside frame");
    property p_sck; COLUMN_SHIFT_CLOCK |=> !COLUMN_SHIFT_CLOCK; endproperty
    a_sck: assert property (p_sck) else $error("shift clock width");
    property p_lp; ROW_LATCH_PULSE |-> !COLUMN_SHIFT_CLOCK ##1 !ROW_LATCH_PULSE; endproperty
    a_lp: assert property (p_lp) else $error("latch pulse");
    property p_hot; $onehot0(ROW_DRIVE); endproperty
    a_hot: assert property (p_hot) else $error("rows not one-hot");
    property p_rchg; !$stable(ROW_DRIVE) |-> ROW_LATCH_PULSE || $past(ROW_LATCH_PULSE); endproperty
    a_rchg: assert property (p_rchg) else $error("rows moved off latch");
    property p_alt; !$stable(ALTERNATION_SIGNAL) |-> ROW_LATCH_PULSE; endproperty
    a_alt: assert property (p_alt) else $error("polarity moved off latch");
    c_alt: cover property ($changed(ALTERNATION_SIGNAL));
    c_busy: cover property ($rose(BUSY_INDICATOR));
    c_lp: cover property (ROW_LATCH_PULSE);
    c_rd: cover property (|HOST_BUS_LINES_OE);
endmodule
bind clhp_top clhp_chk u_chk (.MCLK(MCLK), .ARST_N(ARST_N), .CHIP_SELECT(CHIP_SELECT),
    .DIRECTION_SELECT(DIRECTION_SELECT), .HOST_BUS_LINES_OE(HOST_BUS_LINES_OE),
    .BUSY_INDICATOR(BUSY_INDICATOR), .COLUMN_SHIFT_CLOCK(COLUMN_SHIFT_CLOCK),
    .ROW_LATCH_PULSE(ROW_LATCH_PULSE), .ALTERNATION_SIGNAL(ALTERNATION_SIGNAL),
    .ROW_DRIVE(ROW_DRIVE));

// ===== tb/clhp_bus.sv
module clhp_bus (
    input  wire logic       clk,     // Clock
    input  wire logic [7:0] host_d,  // Host value
    input  wire logic       host_en, // Host drives
    input  wire logic [7:0] dev_d,   // Device value
    input  wire logic [7:0] dev_en,  // Device drives
    output logic      [7:0] line     // Wire level
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] last_ff = 8'h00;
    always_ff @(posedge clk)
        last_ff <= line;
    // Undriven lines toggle so a stale value never passes for data
    always_comb
        for (int i = 0; i < 8; i++)
            line[i] = dev_en[i] ? dev_d[i] : (host_en ? host_d[i] : ~last_ff[i]);
endmodule

// ===== tb/char_lcd_host_port_ram_map_tb.sv
module char_lcd_host_port_ram_map_tb import clhp_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic        mclk, arst_n, rs, dir, cs, hen, busy;
    logic [7:0]  hd, bus, bo, boe, rd;
    logic [15:0] rows;
    int          errors, n_tests;
    clhp_top dut (.MCLK(mclk), .ARST_N(arst_n), .REGISTER_SELECT(rs), .DIRECTION_SELECT(dir),
        .CHIP_SELECT(cs), .HOST_BUS_LINES_I(bus), .HOST_BUS_LINES_O(bo),
        .HOST_BUS_LINES_OE(boe), .BUSY_INDICATOR(busy), .SERIAL_DOTS(),
        .COLUMN_SHIFT_CLOCK(), .ROW_LATCH_PULSE(), .ALTERNATION_SIGNAL(),
        .ROW_DRIVE(rows), .COLUMN_DRIVE());
    clhp_bus host (.clk(mclk), .host_d(hd), .host_en(hen), .dev_d(bo), .dev_en(boe), .line(bus));
    function automatic logic [6:0] nxt(input logic [6:0] a);
        return (a == TEXT_LAST_1) ? PTR_ZERO : a + PTR_ONE;
    endfunction
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic test_done;
        $display("errors %0d n_tests %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Holds select and data across the frame and past the synchroniser delay
    task automatic acc(input logic r, input logic w, input logic [7:0] d);
        @(posedge mclk);
        #2;
        {rs, dir, hd, hen, cs} = {r, w, d, !w, 1'b1};
        repeat (6) @(posedge mclk);
        #2;
        rd = bus;
        cs = 1'b0;
        repeat (4) @(posedge mclk);
        #2;
        hen = 1'b0;
    endtask
    task automatic idle;
        int k;
        k = 0;
        do begin
            acc(1'b0, 1'b1, 8'h00);
            k++;
        end while (rd[7] !== 1'b0 && k < 300);
        if (k >= 300) begin
            errors++;
            test_done();
        end
    endtask
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    initial begin
        logic [6:0] a;
        logic [7:0] d;
        logic [7:0] c;
        {arst_n, rs, dir, cs, hen, hd, rd} = '0;
        errors = 0;
        n_tests = 0;
        void'($urandom(59));
        repeat (6) @(posedge mclk);
        #2;
        arst_n = 1'b1;
        acc(1'b0, 1'b1, 8'h00);
        chk(rd, 8'h00, "status after reset");
        for (int i = 0; i < 5; i++) begin
            a = (i == 0) ? TEXT_LAST_1 : 7'($urandom_range(0, (i == 4) ? 62 : 79));
            d = 8'($urandom);
            // Last pass uses glyph memory
            c = (i == 4) ? {2'b01, a[5:0]} : {1'b1, a};
            acc(1'b0, 1'b0, c);
            acc(1'b0, 1'b1, 8'h00);
            chk({rd[7], 6'h00, busy}, 8'h81, "busy after command");
            idle();
            acc(1'b1, 1'b0, d);
            acc(1'b1, 1'b0, ~d);
            idle();
            chk(rd, {1'b0, nxt(a)}, "pointer after write");
            acc(1'b0, 1'b0, c);
            idle();
            acc(1'b1, 1'b1, 8'h00);
            chk(rd, d, "read after address");
            idle();
            chk(rd, {1'b0, nxt(a)}, "pointer after read");
        end
        chk(rows[15:8], 8'h00, "unused rows");
        test_done();
    end
endmodule
